// File: hw/fpx_pkg.sv
package fpx_pkg;

    // bit positions, numbered from the most significant bit (bit 0) downward
    localparam int CAUSE_MODE_BIT      = 0;
    localparam int CAUSE_DENORM_C_BIT  = 28;
    localparam int CAUSE_DENORM_B_BIT  = 29;
    localparam int CAUSE_DENORM_A_BIT  = 30;
    localparam int CAUSE_TINY_BIT      = 31;

    localparam int STAT_EXC_SUM_BIT    = 0;
    localparam int STAT_ENA_SUM_BIT    = 1;
    localparam int STAT_INV_SUM_BIT    = 2;
    localparam int STAT_OVF_BIT        = 3;
    localparam int STAT_UNF_BIT        = 4;
    localparam int STAT_ZDIV_BIT       = 5;
    localparam int STAT_INEXACT_BIT    = 6;
    localparam int STAT_INV_EN_BIT     = 24;
    localparam int STAT_OVF_EN_BIT     = 25;
    localparam int STAT_UNF_EN_BIT     = 26;
    localparam int STAT_ZDIV_EN_BIT    = 27;
    localparam int STAT_INEXACT_EN_BIT = 28;

    // reset values of both registers
    localparam logic [0:31] CAUSE_RESET = 32'h0000_0000;
    localparam logic [0:31] STAT_RESET  = 32'h0000_0000;

    // writable bits of the cause register; reserved bits read as zero
    localparam logic [0:31] CAUSE_WR_MASK = 32'h8000_000F;
    // sticky exception bits: overflow..invalid-compare (3..12) and 21..23
    localparam logic [0:31] STAT_EXC_MASK = 32'h1FF8_0700;
    // invalid-operation exception bits (7..12 and 21..23)
    localparam logic [0:31] STAT_INV_MASK = 32'h01F8_0700;
    // result fields loaded by every operation (13..19)
    localparam logic [0:31] STAT_RES_MASK = 32'h0007_F000;
    // bits a move instruction may not write: the two summaries and bit 20
    localparam logic [0:31] STAT_RO_MASK  = 32'h6000_0800;

    // move and copy commands toward the status register
    typedef enum logic [5:0] {
        FPX_OP_NONE  = 6'h01,
        FPX_OP_FIELD = 6'h02,
        FPX_OP_IMM   = 6'h04,
        FPX_OP_BCLR  = 6'h08,
        FPX_OP_BSET  = 6'h10,
        FPX_OP_COPY  = 6'h20
    } fpx_op_t;

endpackage

// File: hw/fpx_exc_regs.sv
`timescale 1ns/100ps

// Operation
// - cause bit 0 enables the synchronized ignore-exceptions mode when 1.
// - cause bit 28 shows operand C was denormalized, else 0.
// - cause bit 29 shows operand B was denormalized, else 0.
// - cause bit 30 shows operand A was denormalized, else 0.
// - cause bit 31 shows a tiny result; bits 1 to 27 reserved.
// - exceptions set status bits and are taken precisely.
// - status bit 0 sets on any new exception bit; sticky.
// - copying the field holding bit 0 clears the exception summary.
// - the four move commands may set or clear the exception summary.
// - status bit 1 is OR of exception bits ANDed with enables.
// - enabled summary ignores moves; clears after copy leaves term zero.
// - status bit 2 is OR of all invalid-operation bits.
// - invalid summary ignores moves; clears after copy leaves term zero.
// - status bit 3 records overflow and stays until cleared.
// - status bit 4 records underflow and stays until cleared.
// - in ignore mode re-execute without assist, update both registers.
// - after ignore-mode operation, raise program exception if mode bits and summary.
module fpx_exc_regs
    import fpx_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // floating-point unit completion
    input  wire logic        fpu_done,
    input  wire logic [0:31] fpu_exc,
    input  wire logic [0:31] fpu_result_bits,
    input  wire logic        fpu_assist_need,
    input  wire logic        fpu_denorm_a,
    input  wire logic        fpu_denorm_b,
    input  wire logic        fpu_denorm_c,
    input  wire logic        fpu_tiny,
    // machine-state exception mode bits
    input  wire logic        fp_exc_mode_bit0,
    input  wire logic        fp_exc_mode_bit1,
    // special-purpose register moves of the cause register
    input  wire logic        spr_wr,
    input  wire logic [0:31] spr_wdata,
    // status register move and copy commands
    input  fpx_op_t          fs_op,
    input  wire logic [0:7]  fs_field_mask,
    input  wire logic [2:0]  fs_field,
    input  wire logic [0:3]  fs_imm,
    input  wire logic [4:0]  fs_bit,
    input  wire logic [0:31] fs_wdata,
    // state and events
    output logic      [0:31] fp_exception_cause_q,
    output logic      [0:31] fp_status_control_q,
    output logic      [0:3]  cond_field_q,
    output logic             cond_valid_q,
    output logic             assist_exc_q,
    output logic             enabled_exc_q,
    output logic             program_exc_q
);

    ////////////////////////////////////////////////////////////////////////////
    // cause register

    logic [0:31] cause_d;
    logic        ign_mode;
    logic        cause_load;

    assign ign_mode   = fp_exception_cause_q[CAUSE_MODE_BIT];
    assign cause_load = fpu_done;

    // register move writes mode and status bits; a completion in the same cycle reloads the status bits
    always_comb begin
        cause_d = fp_exception_cause_q;
        if (spr_wr) begin
            cause_d = spr_wdata & CAUSE_WR_MASK;
        end
        if (cause_load) begin
            cause_d[CAUSE_DENORM_C_BIT] = fpu_denorm_c;
            cause_d[CAUSE_DENORM_B_BIT] = fpu_denorm_b;
            cause_d[CAUSE_DENORM_A_BIT] = fpu_denorm_a;
            cause_d[CAUSE_TINY_BIT]     = fpu_tiny;
        end
    end

    // register update
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fp_exception_cause_q <= CAUSE_RESET;
        end else begin
            fp_exception_cause_q <= cause_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status register: explicit moves and copy

    logic [0:31] sel_mask;
    logic [0:31] sel_val;
    logic [0:31] copy_clr;
    logic [0:31] after_cmd;
    logic [0:31] new_exc;
    logic [0:31] after_fpu;
    logic [0:31] status_d;
    logic [0:3]  copy_nib;
    logic        ena_sum_term;
    logic        inv_sum_term;

    // bit mask and value selected by the current move command
    always_comb begin
        sel_mask = 32'h0000_0000;
        sel_val  = 32'h0000_0000;
        case (fs_op)
            FPX_OP_FIELD: begin
                for (int i = 0; i < 8; i++) begin
                    if (fs_field_mask[i]) begin
                        sel_mask[4*i +: 4] = 4'hF;
                    end
                end
                sel_val = fs_wdata;
            end
            FPX_OP_IMM: begin
                sel_mask[4*fs_field +: 4] = 4'hF;
                sel_val[4*fs_field +: 4]  = fs_imm;
            end
            FPX_OP_BCLR: begin
                sel_mask[fs_bit] = 1'b1;
            end
            FPX_OP_BSET: begin
                sel_mask[fs_bit] = 1'b1;
                sel_val[fs_bit]  = 1'b1;
            end
            default: begin
                sel_mask = 32'h0000_0000;
            end
        endcase
    end

    // copy clears the exception bits of the copied field, and the summary only when field 0 is copied
    always_comb begin
        copy_clr = 32'h0000_0000;
        if (fs_op == FPX_OP_COPY) begin
            copy_clr[4*fs_field +: 4] = 4'hF;
        end
        copy_clr = copy_clr & (STAT_EXC_MASK | 32'h8000_0000);
    end

    assign copy_nib = fp_status_control_q[4*fs_field +: 4];

    // the enabled and invalid summaries are never written by moves, only recomputed
    assign after_cmd = ((fp_status_control_q & ~sel_mask)
                      | (sel_val & sel_mask & ~STAT_RO_MASK)
                      | (fp_status_control_q & sel_mask & STAT_RO_MASK))
                      & ~copy_clr;

    ////////////////////////////////////////////////////////////////////////////
    // status register: operation results

    // exception bits that go from zero to one on this completion
    assign new_exc = fpu_done ? (fpu_exc & STAT_EXC_MASK & ~after_cmd)
                              : 32'h0000_0000;

    // an arriving exception wins over a clear in the same cycle
    always_comb begin
        after_fpu = after_cmd | new_exc;
        if (fpu_done) begin
            after_fpu = (after_fpu & ~STAT_RES_MASK)
                      | (fpu_result_bits & STAT_RES_MASK);
        end
        if (|new_exc) begin
            after_fpu[STAT_EXC_SUM_BIT] = 1'b1;
        end
    end

    // enabled summary; the invalid group enters through the fresh invalid summary,
    // so a copy that clears the last invalid bit also drops the enabled summary
    assign ena_sum_term = (inv_sum_term & after_fpu[STAT_INV_EN_BIT])
                        | (after_fpu[STAT_OVF_BIT] & after_fpu[STAT_OVF_EN_BIT])
                        | (after_fpu[STAT_UNF_BIT] & after_fpu[STAT_UNF_EN_BIT])
                        | (after_fpu[STAT_ZDIV_BIT] & after_fpu[STAT_ZDIV_EN_BIT])
                        | (after_fpu[STAT_INEXACT_BIT] & after_fpu[STAT_INEXACT_EN_BIT]);

    assign inv_sum_term = |(after_fpu & STAT_INV_MASK);

    // the enabled and invalid summaries are recomputed every cycle, so moves never reach them
    always_comb begin
        status_d                   = after_fpu;
        status_d[STAT_INV_SUM_BIT] = inv_sum_term;
        status_d[STAT_ENA_SUM_BIT] = ena_sum_term;
    end

    // register update
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fp_status_control_q <= STAT_RESET;
        end else begin
            fp_status_control_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition field and exception events

    logic mode_any;
    logic assist_d;
    logic enabled_d;
    logic program_d;

    assign mode_any  = fp_exc_mode_bit0 | fp_exc_mode_bit1;
    assign assist_d  = fpu_done & fpu_assist_need & ~ign_mode;
    assign enabled_d = fpu_done & ~ign_mode & mode_any
                     & status_d[STAT_ENA_SUM_BIT] & (|new_exc);
    assign program_d = fpu_done & ign_mode & mode_any
                     & status_d[STAT_ENA_SUM_BIT];

    // one-cycle pulses and the copied condition nibble
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cond_field_q  <= 4'h0;
            cond_valid_q  <= 1'b0;
            assist_exc_q  <= 1'b0;
            enabled_exc_q <= 1'b0;
            program_exc_q <= 1'b0;
        end else begin
            cond_field_q  <= (fs_op == FPX_OP_COPY) ? copy_nib : cond_field_q;
            cond_valid_q  <= (fs_op == FPX_OP_COPY);
            assist_exc_q  <= assist_d;
            enabled_exc_q <= enabled_d;
            program_exc_q <= program_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_ena_sum_term: assert property (
        fp_status_control_q[STAT_ENA_SUM_BIT] ==
        ((fp_status_control_q[STAT_INV_SUM_BIT] & fp_status_control_q[STAT_INV_EN_BIT])
       | (fp_status_control_q[STAT_OVF_BIT] & fp_status_control_q[STAT_OVF_EN_BIT])
       | (fp_status_control_q[STAT_UNF_BIT] & fp_status_control_q[STAT_UNF_EN_BIT])
       | (fp_status_control_q[STAT_ZDIV_BIT] & fp_status_control_q[STAT_ZDIV_EN_BIT])
       | (fp_status_control_q[STAT_INEXACT_BIT] & fp_status_control_q[STAT_INEXACT_EN_BIT])))
        else $error("enabled summary differs from its term");

    a_inv_sum_or: assert property (
        fp_status_control_q[STAT_INV_SUM_BIT] == |(fp_status_control_q & STAT_INV_MASK))
        else $error("invalid summary differs from its term");

    a_exc_sum_set: assert property (
        (fpu_done && |(fpu_exc & STAT_EXC_MASK & ~fp_status_control_q)
         && fs_op == FPX_OP_NONE) |=> fp_status_control_q[STAT_EXC_SUM_BIT])
        else $error("exception summary not set by new exception");

    a_ovf_sticky: assert property (
        (fp_status_control_q[STAT_OVF_BIT] && fs_op == FPX_OP_NONE)
        |=> fp_status_control_q[STAT_OVF_BIT])
        else $error("overflow flag dropped without a clear");

    a_unf_sticky: assert property (
        (fp_status_control_q[STAT_UNF_BIT] && fs_op == FPX_OP_NONE)
        |=> fp_status_control_q[STAT_UNF_BIT])
        else $error("underflow flag dropped without a clear");

    a_copy_clears_sum: assert property (
        (fs_op == FPX_OP_COPY && fs_field == 3'h0 && !fpu_done)
        |=> !fp_status_control_q[STAT_EXC_SUM_BIT] && cond_valid_q)
        else $error("copy of field 0 left exception summary set");

    a_ena_move_kept: assert property (
        ((fs_op == FPX_OP_BSET || fs_op == FPX_OP_BCLR)
         && fs_bit == 5'(STAT_ENA_SUM_BIT) && !fpu_done)
        |=> $stable(fp_status_control_q))
        else $error("bit move changed the enabled summary");

    a_inv_move_kept: assert property (
        ((fs_op == FPX_OP_BSET || fs_op == FPX_OP_BCLR)
         && fs_bit == 5'(STAT_INV_SUM_BIT) && !fpu_done)
        |=> $stable(fp_status_control_q))
        else $error("bit move changed the invalid summary");

    a_tiny_follows: assert property (
        fpu_done |=> fp_exception_cause_q[CAUSE_TINY_BIT] == $past(fpu_tiny)
                  && fp_exception_cause_q[CAUSE_DENORM_A_BIT] == $past(fpu_denorm_a))
        else $error("cause status bits not loaded");

    a_reserved_zero: assert property (
        (fp_exception_cause_q & ~CAUSE_WR_MASK) == 32'h0000_0000)
        else $error("reserved cause bits nonzero");

    a_mode_write: assert property (
        spr_wr |=> ign_mode == $past(spr_wdata[CAUSE_MODE_BIT]))
        else $error("ignore mode bit not written");

    a_no_assist_ign: assert property (
        (fpu_done && ign_mode) |=> !assist_exc_q)
        else $error("assist raised in ignore mode");

    a_program_exc: assert property (
        (fpu_done && ign_mode && mode_any) ##1 fp_status_control_q[STAT_ENA_SUM_BIT]
        |-> program_exc_q)
        else $error("program exception missing after ignore-mode operation");

endmodule // fpx_exc_regs

// File: sim/fpx_fpu_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// floating-point unit side: one completion pulse per request
module fpx_fpu_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        go,
    input  wire logic [0:31] exc_in,
    input  wire logic [0:4]  flags_in,
    output logic             fpu_done,
    output logic      [0:31] fpu_exc,
    output logic      [0:31] fpu_result_bits,
    output logic             fpu_assist_need,
    output logic             fpu_denorm_a,
    output logic             fpu_denorm_b,
    output logic             fpu_denorm_c,
    output logic             fpu_tiny
);
    logic [0:31] exc_q;
    logic [0:4]  flg_q;

    // qualifiers are only valid with the pulse; they flip afterwards
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fpu_done <= 1'b0;
            exc_q    <= 32'h0000_0000;
            flg_q    <= 5'h00;
        end else begin
            fpu_done <= go;
            if (go) begin
                exc_q <= exc_in;
                flg_q <= flags_in;
            end else if (fpu_done) begin
                exc_q <= ~exc_q;
                flg_q <= ~flg_q;
            end
        end
    end

    // result fields are zero on completion, garbage otherwise
    assign fpu_exc         = exc_q;
    assign fpu_result_bits = fpu_done ? 32'h0000_0000 : ~exc_q;
    assign {fpu_assist_need, fpu_denorm_a, fpu_denorm_b, fpu_denorm_c, fpu_tiny} = flg_q;
endmodule // fpx_fpu_model

// File: sim/fpx_exc_regs_tb.sv
`timescale 1ns/100ps

module fpx_exc_regs_tb
    import fpx_pkg::*;
;
    typedef struct packed {
        fpx_op_t op; logic [2:0] fld; logic [4:0] bn; logic [0:3] imm;
        logic [0:31] d; logic [0:4] fl; logic [0:31] st; logic [0:31] ca; logic [0:3] cf;
    } fpx_row_t;

    logic clk_sys = 1'b0, nrst = 1'b0, go = 1'b0, spr_wr = 1'b0;
    logic fp_exc_mode_bit0 = 1'b0, fp_exc_mode_bit1 = 1'b0;
    logic [0:31] exc_in = 32'h0, spr_wdata = 32'h0, fs_wdata = 32'h0;
    logic [0:4]  flags_in = 5'h00;
    fpx_op_t     fs_op = FPX_OP_NONE;
    logic [0:7]  fs_field_mask = 8'h00;
    logic [2:0]  fs_field = 3'h0;
    logic [0:3]  fs_imm = 4'h0;
    logic [4:0]  fs_bit = 5'h00;
    logic fpu_done, fpu_assist_need, fpu_denorm_a, fpu_denorm_b, fpu_denorm_c, fpu_tiny;
    logic [0:31] fpu_exc, fpu_result_bits, fp_exception_cause_q, fp_status_control_q;
    logic [0:3]  cond_field_q;
    logic cond_valid_q, assist_exc_q, enabled_exc_q, program_exc_q;
    int error_cnt = 0, num_checks = 0;

    // ordinary cases; op NONE means a floating-point completion with exceptions d
    fpx_row_t rows [14] = '{
        '{FPX_OP_FIELD, 3'h0, 5'h00, 4'h2, 32'h0000_00F0, 5'h00, 32'h0000_00F0, 32'h0, 4'h0},
        '{FPX_OP_NONE,  3'h0, 5'h00, 4'h0, 32'h1000_0000, 5'h08, 32'hD000_00F0, 32'h2, 4'h0},
        '{FPX_OP_BCLR,  3'h0, 5'h01, 4'h0, 32'h0,         5'h00, 32'hD000_00F0, 32'h2, 4'h0},
        '{FPX_OP_BCLR,  3'h0, 5'h00, 4'h0, 32'h0,         5'h00, 32'h5000_00F0, 32'h2, 4'h0},
        '{FPX_OP_BSET,  3'h0, 5'h00, 4'h0, 32'h0,         5'h00, 32'hD000_00F0, 32'h2, 4'h0},
        '{FPX_OP_IMM,   3'h7, 5'h00, 4'h1, 32'h0,         5'h00, 32'hD000_00F1, 32'h2, 4'h0},
        '{FPX_OP_NONE,  3'h0, 5'h00, 4'h0, 32'h0800_0000, 5'h07, 32'hD800_00F1, 32'hD, 4'h0},
        '{FPX_OP_COPY,  3'h0, 5'h00, 4'h0, 32'h0,         5'h00, 32'h4800_00F1, 32'hD, 4'hD},
        '{FPX_OP_COPY,  3'h1, 5'h00, 4'h0, 32'h0,         5'h00, 32'h0000_00F1, 32'hD, 4'h8},
        '{FPX_OP_NONE,  3'h0, 5'h00, 4'h0, 32'h0100_0000, 5'h00, 32'hE100_00F1, 32'h0, 4'h0},
        '{FPX_OP_BCLR,  3'h0, 5'h02, 4'h0, 32'h0,         5'h00, 32'hE100_00F1, 32'h0, 4'h0},
        '{FPX_OP_COPY,  3'h1, 5'h00, 4'h0, 32'h0,         5'h00, 32'h8000_00F1, 32'h0, 4'h1},
        '{FPX_OP_NONE,  3'h0, 5'h00, 4'h0, 32'h0400_0000, 5'h00, 32'hC400_00F1, 32'h0, 4'h0},
        '{FPX_OP_FIELD, 3'h0, 5'h00, 4'h2, 32'h0000_0000, 5'h00, 32'h8400_0001, 32'h0, 4'h0}};

    fpx_exc_regs dut (.clk_sys(clk_sys), .nrst(nrst), .fpu_done(fpu_done), .fpu_exc(fpu_exc),
        .fpu_result_bits(fpu_result_bits), .fpu_assist_need(fpu_assist_need),
        .fpu_denorm_a(fpu_denorm_a), .fpu_denorm_b(fpu_denorm_b), .fpu_denorm_c(fpu_denorm_c),
        .fpu_tiny(fpu_tiny), .fp_exc_mode_bit0(fp_exc_mode_bit0),
        .fp_exc_mode_bit1(fp_exc_mode_bit1), .spr_wr(spr_wr), .spr_wdata(spr_wdata),
        .fs_op(fs_op), .fs_field_mask(fs_field_mask), .fs_field(fs_field), .fs_imm(fs_imm),
        .fs_bit(fs_bit), .fs_wdata(fs_wdata), .fp_exception_cause_q(fp_exception_cause_q),
        .fp_status_control_q(fp_status_control_q), .cond_field_q(cond_field_q),
        .cond_valid_q(cond_valid_q), .assist_exc_q(assist_exc_q),
        .enabled_exc_q(enabled_exc_q), .program_exc_q(program_exc_q));

    fpx_fpu_model fpu (.clk_sys(clk_sys), .nrst(nrst), .go(go), .exc_in(exc_in),
        .flags_in(flags_in), .fpu_done(fpu_done), .fpu_exc(fpu_exc),
        .fpu_result_bits(fpu_result_bits), .fpu_assist_need(fpu_assist_need),
        .fpu_denorm_a(fpu_denorm_a), .fpu_denorm_b(fpu_denorm_b),
        .fpu_denorm_c(fpu_denorm_c), .fpu_tiny(fpu_tiny));

    ////////////////////////////////////////////////////////////////////////////
    // clock, compare and bus tasks
    initial forever #5 clk_sys = ~clk_sys;

    task automatic chk_word(input logic [0:31] got, input logic [0:31] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // completion is seen one edge after the request, results one edge later
    task automatic fpu_run(input logic [0:31] e, input logic [0:4] f);
        @(posedge clk_sys);
        go <= 1'b1;
        exc_in <= e;
        flags_in <= f;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic fs_cmd(input fpx_op_t op, input logic [2:0] fld, input logic [4:0] bn,
                          input logic [0:3] imm, input logic [0:31] d);
        @(posedge clk_sys);
        fs_op <= op;
        fs_field <= fld;
        fs_bit <= bn;
        fs_imm <= imm;
        fs_field_mask <= {4'h0, imm};
        fs_wdata <= d;
        @(posedge clk_sys);
        fs_op <= FPX_OP_NONE;
        #1;
    endtask

    task automatic spr_put(input logic [0:31] d);
        @(posedge clk_sys);
        spr_wr <= 1'b1;
        spr_wdata <= d;
        @(posedge clk_sys);
        spr_wr <= 1'b0;
        #1;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog and main sequence
    initial begin
        #20000;
        error_cnt++;
        results;
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk_word(fp_status_control_q, STAT_RESET);
        chk_word(fp_exception_cause_q, CAUSE_RESET);
        // registers are compared only after the completion has landed
        foreach (rows[i]) begin
            if (rows[i].op == FPX_OP_NONE) fpu_run(rows[i].d, rows[i].fl);
            else fs_cmd(rows[i].op, rows[i].fld, rows[i].bn, rows[i].imm, rows[i].d);
            chk_word(fp_status_control_q, rows[i].st);
            chk_word(fp_exception_cause_q, rows[i].ca);
            if (rows[i].op == FPX_OP_COPY) begin
                chk_word({28'h0, cond_field_q}, {28'h0, rows[i].cf});
                chk_bit(cond_valid_q, 1'b1);
            end else begin
                chk_bit(cond_valid_q, 1'b0);
            end
        end
        // a move of all ones into the cause register keeps only the writable bits
        spr_put(32'hFFFF_FFFF);
        chk_word(fp_exception_cause_q, 32'h8000_000F);
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_word(fp_status_control_q, STAT_RESET);
        chk_word(fp_exception_cause_q, CAUSE_RESET);
        @(posedge clk_sys);
        nrst <= 1'b1;
        fs_cmd(FPX_OP_FIELD, 3'h0, 5'h00, 4'h2, 32'h0000_0040);
        @(posedge clk_sys);
        fp_exc_mode_bit0 <= 1'b1;
        fpu_run(32'h1000_0000, 5'h10);
        chk_word(fp_status_control_q, 32'hD000_0040);
        chk_bit(assist_exc_q, 1'b1);
        chk_bit(enabled_exc_q, 1'b1);
        chk_bit(program_exc_q, 1'b0);
        spr_put(32'h8000_0000);
        fpu_run(32'h1000_0000, 5'h10);
        chk_bit(assist_exc_q, 1'b0);
        chk_bit(program_exc_q, 1'b1);
        chk_word(fp_exception_cause_q, 32'h8000_0000);
        chk_bit(enabled_exc_q, 1'b0);
        // the other exception mode bit alone also raises the program exception
        @(posedge clk_sys);
        fp_exc_mode_bit0 <= 1'b0;
        fp_exc_mode_bit1 <= 1'b1;
        fpu_run(32'h0000_0000, 5'h00);
        chk_bit(program_exc_q, 1'b1);
        chk_bit(assist_exc_q, 1'b0);
        results;
    end
endmodule // fpx_exc_regs_tb
